// *** core/phcp_device.sv ***
// Converter end of the parallel host command port
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "phcp_params.svh"
// Behaviour
// - Parallel mode active while select pin low
// - Instruction write or status read clears interrupt
// - Interrupt raised when power-on reset completes
// - Interrupt after configuration load finishes
// - Read: select high status, low data
// - Write: select high instruction, low data
// - Status driven onto bus while chip-selected
// - Bit 15 set while instruction executes
// - Bit 14 data ready, 13 data request
// - Bit 12 identity error, 11 integrity error
// - Bit 10 set on conversion overflow
// - Bits 9..1 mirror instruction bits
// - Bit 0 set when configured, ready
// - Stream conversions until abort instruction
// - Abort stops activity, keeps configuration
// - Load requests each word by interrupt
// - Word request cleared at chip-select fall
// - Final interrupt after last configuration word
// - Unmasked load interrupts on bad data
// - Bad identity word never committed; a bad checksum on the last word still commits
// - Masked load: no error interrupts, 504 words
// - ROM boot loads default without transfer
// - Conversion interrupt held until word read; the code clears it on any bus cycle
module phcp_device
  import phcp_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  phcp_if.device bus,
  input wire logic [15:0] sample_in,
  input wire logic overflow_in,
  output logic configured_out,
  output logic [15:0] coeff_word_out,
  output logic coeff_commit_out
);
  import phcp_pkg::*;
  phcp_dev_state_t state_reg;
  phcp_word_t instr_reg;
  phcp_word_t data_reg;
  logic cs_n_reg;
  logic irq_reg;
  logic por_reg;
  logic late_set_reg;
  logic masked_reg;
  logic drdy_reg;
  logic dreq_reg;
  logic configuration_complete_flag_reg;
  logic dataerr_reg;
  logic [9:0] widx_reg;
  logic [7:0] div_reg;
  logic [15:0] dout_reg;
  logic doe_reg;
  logic id_bad;
  logic crc_bad;
  // Bus strobes, sampled against the previous chip-select level
  wire par_mode = !bus.sp_sel;
  wire cs_fall = par_mode && cs_n_reg && !bus.cs_n;
  wire wr_instr = cs_fall && !bus.rd_wr_n && bus.register_select;
  wire wr_data = cs_fall && !bus.rd_wr_n && !bus.register_select;
  wire rd_stat = cs_fall && bus.rd_wr_n && bus.register_select;
  wire rd_data = cs_fall && bus.rd_wr_n && !bus.register_select;
  wire [15:0] cmd = bus.bus_d;
  wire cmd_known = cmd == `PHCP_CMD_FETCH_ID || cmd == `PHCP_CMD_STREAM ||
    cmd == `PHCP_CMD_LOAD || cmd == `PHCP_CMD_LOAD_MASKED ||
    cmd == `PHCP_CMD_ABORT || cmd == `PHCP_CMD_ROM_BOOT;
  wire take_cmd = wr_instr && cmd_known;
  wire load_word = wr_data && state_reg == PHCP_DS_LOAD && dreq_reg;
  wire last_word = load_word && widx_reg == `PHCP_CFG_WORDS - 10'h001;
  wire conv_tick = state_reg == PHCP_DS_STREAM && div_reg == 8'h00;
  wire cfg_bad = id_bad || crc_bad;
  wire [15:0] status_word = {state_reg != PHCP_DS_IDLE, drdy_reg, dreq_reg, id_bad,
    crc_bad, dataerr_reg, instr_reg[15], instr_reg[13], instr_reg[12], instr_reg[11],
    instr_reg[6], instr_reg[5], instr_reg[4], instr_reg[1], instr_reg[0],
    configuration_complete_flag_reg};
  // Detect a bad first word early so the unmasked load can flag it
  wire id_now = load_word && widx_reg == 10'h000 && cmd != `PHCP_CFG_ID_WORD;

  phcp_cfg_check u_check (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .clear_in(take_cmd && (cmd == `PHCP_CMD_LOAD || cmd == `PHCP_CMD_LOAD_MASKED)),
    .word_in_valid(load_word),
    .word_in(cmd),
    .index_in(widx_reg),
    .id_bad_out(id_bad),
    .crc_bad_out(crc_bad)
  );

  // Chip-select history and power-on marker
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cs_n_reg <= 1'b1;
      por_reg <= 1'b1;
      late_set_reg <= 1'b0;
    end else begin
      cs_n_reg <= bus.cs_n;
      por_reg <= 1'b0;
      // Done or error interrupt one clock late, so the write cycle's clear shows first
      late_set_reg <= last_word || (id_now && !masked_reg);
    end
  end

  // Instruction sequencer
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= PHCP_DS_IDLE;
      instr_reg <= 16'h0000;
      masked_reg <= 1'b0;
      widx_reg <= 10'h000;
      div_reg <= 8'h00;
    end else if (take_cmd) begin
      instr_reg <= cmd;
      widx_reg <= 10'h000;
      div_reg <= `PHCP_CONV_DIV - 8'h01;
      masked_reg <= cmd == `PHCP_CMD_LOAD_MASKED;
      case (cmd)
        `PHCP_CMD_LOAD, `PHCP_CMD_LOAD_MASKED: state_reg <= PHCP_DS_LOAD;
        `PHCP_CMD_ROM_BOOT: state_reg <= PHCP_DS_ROM;
        `PHCP_CMD_STREAM: state_reg <= configuration_complete_flag_reg ? PHCP_DS_STREAM : PHCP_DS_IDLE;
        `PHCP_CMD_FETCH_ID: state_reg <= PHCP_DS_ID;
        default: state_reg <= PHCP_DS_IDLE;
      endcase
    end else begin
      case (state_reg)
        PHCP_DS_LOAD: begin
          if (load_word) widx_reg <= widx_reg + 10'h001;
          if (last_word) state_reg <= PHCP_DS_IDLE;
        end
        PHCP_DS_ROM: begin
          widx_reg <= widx_reg + 10'h001;
          if (widx_reg == `PHCP_ROM_CYCLES) state_reg <= PHCP_DS_IDLE;
        end
        PHCP_DS_STREAM: div_reg <= conv_tick ? `PHCP_CONV_DIV - 8'h01 : div_reg - 8'h01;
        PHCP_DS_ID: if (rd_data) state_reg <= PHCP_DS_IDLE;
        default: state_reg <= state_reg;
      endcase
    end
  end

  // Status flags, data word and configuration commit
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      drdy_reg <= 1'b0;
      dreq_reg <= 1'b0;
      configuration_complete_flag_reg <= 1'b0;
      dataerr_reg <= 1'b0;
      data_reg <= 16'h0000;
      coeff_word_out <= 16'h0000;
      coeff_commit_out <= 1'b0;
      configured_out <= 1'b0;
    end else begin
      coeff_commit_out <= 1'b0;
      configured_out <= configuration_complete_flag_reg;
      if (take_cmd) begin
        drdy_reg <= cmd == `PHCP_CMD_FETCH_ID;
        data_reg <= cmd == `PHCP_CMD_FETCH_ID ? `PHCP_CFG_ID_WORD : data_reg;
        dreq_reg <= cmd == `PHCP_CMD_LOAD || cmd == `PHCP_CMD_LOAD_MASKED;
        if (cmd != `PHCP_CMD_ABORT && cmd != `PHCP_CMD_FETCH_ID) dataerr_reg <= 1'b0;
        if (cmd == `PHCP_CMD_LOAD || cmd == `PHCP_CMD_LOAD_MASKED ||
            cmd == `PHCP_CMD_ROM_BOOT) configuration_complete_flag_reg <= 1'b0;
      end else begin
        if (conv_tick) begin
          data_reg <= sample_in;
          dataerr_reg <= overflow_in;
        end
        if (conv_tick) drdy_reg <= 1'b1;
        else if (rd_data) drdy_reg <= 1'b0;
        if (last_word) dreq_reg <= 1'b0;
        if (last_word && !cfg_bad && !id_now) begin
          configuration_complete_flag_reg <= 1'b1;
          coeff_commit_out <= 1'b1;
        end
        if (state_reg == PHCP_DS_ROM && widx_reg == `PHCP_ROM_CYCLES) begin
          configuration_complete_flag_reg <= 1'b1;
          coeff_commit_out <= 1'b1;
        end
      end
      if (load_word) coeff_word_out <= cmd;
    end
  end

  // Interrupt: set events win over clears; an instruction write beats a conversion tick
  wire irq_set = por_reg || (state_reg == PHCP_DS_LOAD && !load_word && dreq_reg &&
    cs_n_reg && !irq_reg && !wr_data) || late_set_reg || (conv_tick && !wr_instr) ||
    (state_reg == PHCP_DS_ROM && widx_reg == `PHCP_ROM_CYCLES);
  wire irq_clr = wr_instr || rd_stat || wr_data || rd_data;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_reg <= 1'b0;
    end else if (irq_set && !(state_reg == PHCP_DS_LOAD && !last_word && load_word)) begin
      irq_reg <= 1'b1;
    end else if (irq_clr || take_cmd) begin
      irq_reg <= 1'b0;
    end
  end
  assign bus.irq = irq_reg;

  // Read data drive while chip-selected
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dout_reg <= 16'h0000;
      doe_reg <= 1'b0;
    end else begin
      doe_reg <= par_mode && !bus.cs_n && bus.rd_wr_n;
      dout_reg <= bus.register_select ? status_word : data_reg;
    end
  end
  assign bus.dev_d = dout_reg;
  assign bus.dev_d_oe = doe_reg;
endmodule : phcp_device

// *** core/phcp_params.svh ***
// Constants for the parallel host command port: codes, status bit positions, counts
`ifndef PHCP_PARAMS_SVH
`define PHCP_PARAMS_SVH
`define PHCP_CMD_FETCH_ID 16'h8802
`define PHCP_CMD_STREAM 16'h8D21
`define PHCP_CMD_LOAD 16'h1800
`define PHCP_CMD_LOAD_MASKED 16'h1A00
`define PHCP_CMD_ABORT 16'h0000
`define PHCP_CMD_ROM_BOOT 16'h2000
`define PHCP_ST_BUSY 15
`define PHCP_ST_DRDY 14
`define PHCP_ST_DREQ 13
`define PHCP_ST_IDERR 12
`define PHCP_ST_CRCERR 11
`define PHCP_ST_DATAERR 10
`define PHCP_ST_CONFIGURATION_COMPLETE_FLAG 0
`define PHCP_CFG_WORDS 10'h1F8
// Configuration identity word; the value is arbitrary
`define PHCP_CFG_ID_WORD 16'h4B1D
`define PHCP_ROM_CYCLES 10'h010
`define PHCP_CONV_DIV 8'h20
`define PHCP_HOST_STATUS_OFF 8'h00
`define PHCP_HOST_CMD_OFF 8'h04
`define PHCP_HOST_WDATA_OFF 8'h08
`define PHCP_HOST_RDATA_OFF 8'h0C
`define PHCP_HOST_PSTAT_OFF 8'h10
`define PHCP_HOST_CTRL_OFF 8'h14
`endif

// *** core/phcp_pkg.sv ***
// Types shared by both ends of the parallel host command port
package phcp_pkg;
  typedef logic [15:0] phcp_word_t;
  typedef enum logic [4:0] {
    PHCP_DS_IDLE = 5'h01,
    PHCP_DS_LOAD = 5'h02,
    PHCP_DS_ROM = 5'h04,
    PHCP_DS_STREAM = 5'h08,
    PHCP_DS_ID = 5'h10
  } phcp_dev_state_t;
  typedef enum logic [3:0] {
    PHCP_HS_IDLE = 4'h1,
    PHCP_HS_SETUP = 4'h2,
    PHCP_HS_STROBE = 4'h4,
    PHCP_HS_DONE = 4'h8
  } phcp_host_state_t;
endpackage : phcp_pkg

// *** core/phcp_if.sv ***
// Parallel bus between the host end and the converter end
`timescale 1ns/1ps
interface phcp_if;
  logic rd_wr_n;
  logic cs_n;
  logic register_select;
  logic [15:0] host_d;
  logic host_d_oe;
  logic [15:0] dev_d;
  logic dev_d_oe;
  logic irq;
  logic sp_sel;
  wire [15:0] bus_d;
  // Resolved data bus level from the two enables
  assign bus_d = dev_d_oe ? dev_d : (host_d_oe ? host_d : 16'h0000);
  modport device (input rd_wr_n, input cs_n, input register_select, input bus_d,
    input sp_sel, output dev_d, output dev_d_oe, output irq);
  modport host (output rd_wr_n, output cs_n, output register_select, output host_d,
    output host_d_oe, output sp_sel, input bus_d, input irq);
endinterface : phcp_if

// *** core/phcp_cfg_check.sv ***
// Running integrity check over configuration words
`timescale 1ns/1ps
`include "phcp_params.svh"
module phcp_cfg_check (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic clear_in,
  input wire logic word_in_valid,
  input wire logic [15:0] word_in,
  input wire logic [9:0] index_in,
  output logic id_bad_out,
  output logic crc_bad_out
);
  logic [15:0] sum_reg;
  wire last_word = (index_in == `PHCP_CFG_WORDS - 10'h001);
  // Sum of all words except the last; last word must equal the sum
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sum_reg <= 16'h0000;
      id_bad_out <= 1'b0;
      crc_bad_out <= 1'b0;
    end else if (clear_in) begin
      sum_reg <= 16'h0000;
      id_bad_out <= 1'b0;
      crc_bad_out <= 1'b0;
    end else if (word_in_valid) begin
      sum_reg <= sum_reg + word_in;
      if (index_in == 10'h000 && word_in != `PHCP_CFG_ID_WORD) id_bad_out <= 1'b1;
      if (last_word && word_in != sum_reg) crc_bad_out <= 1'b1;
    end
  end
endmodule : phcp_cfg_check

// *** core/phcp_host.sv ***
// Host end: AXI4-Lite registers driving the parallel bus cycles
`timescale 1ns/1ps
`include "phcp_params.svh"
module phcp_host
  import phcp_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  phcp_if.host bus,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import phcp_pkg::*;
  phcp_host_state_t hs_reg;
  logic aw_reg, w_reg;
  logic [7:0] awaddr_reg;
  logic [15:0] wdata_reg;
  logic [15:0] status_reg, rdata_reg, out_reg;
  logic rdwr_reg, rs_reg, cs_reg, oe_reg;
  logic strobe_wait_reg;
  // Write channel: accept address and data in either order
  wire wr_go = aw_reg && w_reg && !s_axi_bvalid;
  wire wr_ok = awaddr_reg == `PHCP_HOST_CMD_OFF || awaddr_reg == `PHCP_HOST_WDATA_OFF ||
    awaddr_reg == `PHCP_HOST_CTRL_OFF;
  wire cyc_go = wr_go && wr_ok && hs_reg == PHCP_HS_IDLE;
  wire rd_ok = s_axi_araddr == `PHCP_HOST_STATUS_OFF || s_axi_araddr == `PHCP_HOST_RDATA_OFF
    || s_axi_araddr == `PHCP_HOST_PSTAT_OFF || s_axi_araddr == `PHCP_HOST_CTRL_OFF;
  wire [31:0] rd_mux = s_axi_araddr == `PHCP_HOST_STATUS_OFF ? {16'h0000, status_reg} :
    s_axi_araddr == `PHCP_HOST_RDATA_OFF ? {16'h0000, rdata_reg} :
    s_axi_araddr == `PHCP_HOST_PSTAT_OFF ? {30'h0, bus.irq, hs_reg != PHCP_HS_IDLE} :
    32'h0000_0000;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      aw_reg <= 1'b0;
      w_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 16'h0000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_reg <= 1'b1;
        wdata_reg <= s_axi_wdata[15:0];
      end
      // Bus cycle writes wait for an idle port; unmapped ones answer at once
      if (wr_go && (hs_reg == PHCP_HS_IDLE || !wr_ok)) begin
        aw_reg <= 1'b0;
        w_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !aw_reg;
  assign s_axi_wready = !w_reg;
  // Read channel: one cycle answer, status and data latched by bus cycles
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_arready = !s_axi_rvalid;
  // Parallel bus cycle: CTRL bit1 = read, bit0 = register select
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hs_reg <= PHCP_HS_IDLE;
      rdwr_reg <= 1'b1;
      rs_reg <= 1'b0;
      cs_reg <= 1'b1;
      oe_reg <= 1'b0;
      strobe_wait_reg <= 1'b0;
      out_reg <= 16'h0000;
      status_reg <= 16'h0000;
      rdata_reg <= 16'h0000;
    end else begin
      case (hs_reg)
        PHCP_HS_IDLE: if (cyc_go) begin
          hs_reg <= PHCP_HS_SETUP;
          out_reg <= wdata_reg;
          rdwr_reg <= awaddr_reg == `PHCP_HOST_CTRL_OFF ? wdata_reg[1] : 1'b0;
          rs_reg <= awaddr_reg == `PHCP_HOST_CTRL_OFF ? wdata_reg[0] :
            awaddr_reg == `PHCP_HOST_CMD_OFF;
          oe_reg <= !(awaddr_reg == `PHCP_HOST_CTRL_OFF && wdata_reg[1]);
        end
        PHCP_HS_SETUP: begin
          cs_reg <= 1'b0;
          hs_reg <= PHCP_HS_STROBE;
        end
        // Two strobe clocks: the device drives its word one clock after the fall
        PHCP_HS_STROBE: begin
          strobe_wait_reg <= !strobe_wait_reg;
          if (strobe_wait_reg && rdwr_reg && rs_reg) status_reg <= bus.bus_d;
          if (strobe_wait_reg && rdwr_reg && !rs_reg) rdata_reg <= bus.bus_d;
          if (strobe_wait_reg) hs_reg <= PHCP_HS_DONE;
        end
        PHCP_HS_DONE: begin
          cs_reg <= 1'b1;
          oe_reg <= 1'b0;
          rdwr_reg <= 1'b1;
          hs_reg <= PHCP_HS_IDLE;
        end
        default: hs_reg <= PHCP_HS_IDLE;
      endcase
    end
  end
  assign bus.rd_wr_n = rdwr_reg;
  assign bus.register_select = rs_reg;
  assign bus.cs_n = cs_reg;
  assign bus.host_d = out_reg;
  assign bus.host_d_oe = oe_reg;
  assign bus.sp_sel = 1'b0;
endmodule : phcp_host

// *** verif/phcp_monitor.sv ***
// Checker on the parallel bus between the host end and the converter end
`timescale 1ns/1ps
module phcp_monitor (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic rd_wr_n,
  input wire logic cs_n,
  input wire logic register_select,
  input wire logic host_d_oe,
  input wire logic dev_d_oe,
  input wire logic irq,
  input wire logic sp_sel,
  input wire logic [15:0] bus_d
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  // Cycle starts as seen at the chip-select fall; instruction writes with unknown codes are not checked
  sequence s_ins_wr;
    $fell(cs_n) && !rd_wr_n && register_select &&
      (bus_d inside {16'h8802, 16'h8D21, 16'h1800, 16'h1A00, 16'h0000, 16'h2000});
  endsequence
  sequence s_st_rd;
    $fell(cs_n) && rd_wr_n && register_select;
  endsequence
  sequence s_dat_wr;
    $fell(cs_n) && !rd_wr_n && !register_select;
  endsequence
  // Select held for at least two clocks, then released within two more
  sequence s_frame;
    !cs_n [*2] ##[0:2] cs_n;
  endsequence
  sel_parallel_a: assert property (!sp_sel)
    else $error("serial mode selected");
  one_driver_a: assert property (!cs_n |-> !(dev_d_oe && host_d_oe))
    else $error("both ends drive the data bus");
  read_answer_a: assert property ($fell(cs_n) && rd_wr_n |-> ##[0:2] dev_d_oe)
    else $error("device did not answer a read");
  dev_drive_a: assert property ($rose(dev_d_oe) |-> rd_wr_n && !cs_n)
    else $error("device drove outside a read");
  host_drive_a: assert property (!cs_n && host_d_oe |-> !rd_wr_n)
    else $error("host drove during a read");
  cs_frame_a: assert property ($fell(cs_n) |-> s_frame)
    else $error("chip select length wrong");
  por_irq_a: assert property ($rose(rst_n_in) |-> ##[0:3] irq)
    else $error("no interrupt after reset");
  ins_clear_a: assert property (s_ins_wr |-> ##[1:3] !irq)
    else $error("instruction did not clear interrupt");
  stat_clear_a: assert property (s_st_rd |-> ##[1:3] !irq)
    else $error("status read did not clear interrupt");
  word_clear_a: assert property (s_dat_wr |-> ##[1:3] !irq)
    else $error("data write did not clear request");
endmodule : phcp_monitor

// *** verif/tb.sv ***
// Bench: host end and converter end joined, driven over AXI4-Lite
`timescale 1ns/1ps
module tb;
  import phcp_pkg::*;
  logic clk_in, rst_n_in, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, last_resp;
  logic [15:0] sample_in, coeff_word_out;
  logic overflow_in, configured_out, coeff_commit_out;
  int miscompares = 0;
  int n_compared = 0;
  int n_commit = 0;
  phcp_if i_phcp_if ();
  phcp_device i_phcp_device (.clk_in, .rst_n_in, .bus(i_phcp_if), .sample_in, .overflow_in,
    .configured_out, .coeff_word_out, .coeff_commit_out);
  phcp_host i_phcp_host (.clk_in, .rst_n_in, .bus(i_phcp_if), .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  phcp_monitor i_phcp_monitor (.clk_in, .rst_n_in, .rd_wr_n(i_phcp_if.rd_wr_n),
    .cs_n(i_phcp_if.cs_n), .register_select(i_phcp_if.register_select),
    .host_d_oe(i_phcp_if.host_d_oe), .dev_d_oe(i_phcp_if.dev_d_oe), .irq(i_phcp_if.irq),
    .sp_sel(i_phcp_if.sp_sel), .bus_d(i_phcp_if.bus_d));
  assign irq = i_phcp_if.irq;
  // Clock and commit pulse count
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  always @(posedge clk_in) if (coeff_commit_out === 1'b1) n_commit++;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (e !== g) begin
      miscompares++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk
  // One AXI transfer; handshakes read at the falling edge, so no race with the slave
  task automatic bus_op(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    logic ta, tw, done;
    done = 1'b0;
    @(posedge clk_in);
    if (wr) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end
    while (!done) begin
      @(negedge clk_in);
      ta = (s_axi_awvalid & s_axi_awready) | (s_axi_arvalid & s_axi_arready);
      tw = s_axi_wvalid & s_axi_wready;
      done = wr ? (s_axi_bvalid & s_axi_bready) : (s_axi_rvalid & s_axi_rready);
      last_resp = wr ? s_axi_bresp : s_axi_rresp;
      q = s_axi_rdata;
      @(posedge clk_in);
      if (ta) s_axi_awvalid <= 1'b0;
      if (ta) s_axi_arvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
  endtask : bus_op
  task automatic cmd(input logic [15:0] w);
    logic [31:0] q;
    bus_op(1'b1, 8'h04, {16'h0000, w}, q);
  endtask : cmd
  // Parallel read cycle, then poll port busy before fetching the captured word
  task automatic par_rd(input logic rs, output logic [31:0] q);
    bus_op(1'b1, 8'h14, {30'h0, 1'b1, rs}, q);
    for (int k = 0; k < 20; k++) begin
      bus_op(1'b0, 8'h10, 32'h0, q);
      if (q[0] === 1'b0) break;
    end
    chk("port idle", 0, q[0]);
    bus_op(1'b0, rs ? 8'h00 : 8'h0C, 32'h0, q);
  endtask : par_rd
  task automatic wait_irq(input int n);
    for (int k = 0; k < n; k++) begin
      @(negedge clk_in);
      if (irq === 1'b1) break;
    end
  endtask : wait_irq
  task automatic t_power();
    logic [31:0] st, st2;
    wait_irq(10);
    chk("por irq", 1, irq);
    par_rd(1'b1, st);
    chk("configuration_complete_flag", 0, st[0]);
    cmd(16'h1234);
    par_rd(1'b1, st2);
    chk("unknown code", st, st2);
    $display("t_power done");
  endtask : t_power
  task automatic t_id();
    logic [31:0] st;
    cmd(16'h8802);
    par_rd(1'b1, st);
    chk("mirror", 9'h122, st[9:1]);
    chk("drdy", 1, st[14]);
    par_rd(1'b0, st);
    chk("id word", 32'h0000_4B1D, st);
    par_rd(1'b1, st);
    chk("drdy clear", 0, st[14]);
    $display("t_id done");
  endtask : t_id
  // Full configuration file; a bad first word must keep the storage untouched
  task automatic t_load(input logic masked, input logic good);
    logic [15:0] w, sum;
    logic [31:0] st;
    int c0;
    c0 = n_commit;
    sum = 16'h0000;
    cmd(masked ? 16'h1A00 : 16'h1800);
    for (int i = 0; i < 504; i++) begin
      w = (i == 0) ? (good ? 16'h4B1D : 16'h1111) : ((i == 503) ? sum : 16'(i * 7));
      sum = sum + w;
      bus_op(1'b1, 8'h08, {16'h0000, w}, st);
      if (i == 10 && !masked) begin
        wait_irq(20);
        chk("word req irq", 1, irq);
        par_rd(1'b1, st);
        chk("busy", 1, st[15]);
        chk("dreq", 1, st[13]);
      end
    end
    // Let the last write cycle finish, so a stale word request cannot pass for done
    repeat (8) @(negedge clk_in);
    wait_irq(40);
    chk("done irq", 1, irq);
    par_rd(1'b1, st);
    chk("id err", !good, st[12]);
    chk("commit", c0 + good, n_commit);
    if (good) begin
      chk("configuration_complete_flag", 1, st[0]);
      chk("configured", 1, configured_out);
      chk("last word", w, coeff_word_out);
    end
    $display("t_load done");
  endtask : t_load
  // Streaming with a changed sample, an overflow, then abort
  task automatic t_stream();
    logic [31:0] d;
    logic hit;
    hit = 1'b0;
    cmd(16'h8D21);
    wait_irq(80);
    chk("conv irq", 1, irq);
    par_rd(1'b0, d);
    chk("conv 1", 16'h3C5A, d[15:0]);
    @(posedge clk_in);
    sample_in <= 16'hA5C3;
    overflow_in <= 1'b1;
    wait_irq(80);
    chk("conv irq 2", 1, irq);
    par_rd(1'b0, d);
    chk("conv 2", 16'hA5C3, d[15:0]);
    cmd(16'h0000);
    repeat (10) @(negedge clk_in);
    repeat (80) @(negedge clk_in) if (irq !== 1'b0) hit = 1'b1;
    chk("stopped", 0, hit);
    par_rd(1'b1, d);
    chk("overflow", 1, d[10]);
    chk("still cfg", 1, d[0]);
    $display("t_stream done");
  endtask : t_stream
  task automatic t_rom_unmapped();
    logic [31:0] q;
    int c0;
    c0 = n_commit;
    cmd(16'h2000);
    repeat (40) @(posedge clk_in);
    chk("rom commit", c0 + 1, n_commit);
    bus_op(1'b0, 8'h3C, 32'h0, q);
    chk("unmapped rd", 2'b10, last_resp);
    bus_op(1'b1, 8'h3C, 32'h0, q);
    chk("unmapped wr", 2'b10, last_resp);
    $display("t_rom_unmapped done");
  endtask : t_rom_unmapped
  task test_done();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done
  // Watchdog: the three loads dominate the run
  initial begin
    #2400000;
    miscompares++;
    test_done();
  end
  // Reset, then the tests in order
  initial begin
    rst_n_in = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    sample_in = 16'h3C5A;
    overflow_in = 1'b0;
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_power();
    t_id();
    t_load(1'b1, 1'b0);
    t_load(1'b0, 1'b0);
    t_load(1'b0, 1'b1);
    t_stream();
    t_rom_unmapped();
    test_done();
  end
endmodule : tb
